/* src/bfd_decoder.sv */
// Purpose: splits instruction words into fields and resolves branch targets
// Assumes: one word per cycle from fetch; tables supply per-instruction masks
// Notes: all outputs registered, one cycle after the word is taken
`timescale 1ns/1ps
`default_nettype none
`include "bfd_params.svh"

module bfd_decoder #(
  parameter int ADDR_W = 64
) (
  input wire logic clk_i, // core clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic instr_valid_i, // word present this cycle
  input wire logic [31:0] instr_i, // instruction word, bit 0 is msb
  input wire logic [ADDR_W-1:0] instr_addr_i, // fetch address of the word
  input wire bfd_pkg::bfd_form_t form_i, // form from the opcode table
  input wire logic wide_mode_i, // 1: 64-bit extension, 0: 32-bit
  input wire logic [31:0] rsvd_mask_i, // reserved bits of this instruction
  input wire logic [31:0] fixed_mask_i, // bits that must hold a constant
  input wire logic [31:0] fixed_value_i, // that constant
  input wire logic split_swap_i, // capitalized split field reversed
  input wire logic use_float_status_i, // field selects act on float status
  input wire logic [31:0] condition_reg_i, // condition register
  input wire logic [31:0] float_status_ctrl_reg_i, // float status/control
  output logic valid_o, // outputs below hold a decoded word
  output logic invalid_o, // form invalid
  output logic [5:0] primary_opcode_o, // bits 0-5
  output logic record_bit_o, // bit 31
  output logic absolute_addr_bit_o, // bit 30
  output logic [9:0] extended_opcode_o, // form dependent width
  output logic oe_bit_o, // overflow enable, overflow form only
  output logic [4:0] rt_o, // bits 6-10
  output logic [4:0] ra_o, // bits 11-15
  output logic [4:0] rb_o, // bits 16-20
  output logic [4:0] src_c_o, // bits 21-25
  output logic [7:0] float_field_mask_o, // bits 7-14
  output logic [4:0] float_src_b_o, // bits 16-20
  output logic [9:0] split_field_o, // reassembled split field
  output logic [4:0] branch_cond_bit_o, // index of tested bit
  output logic branch_cond_o, // value of tested bit
  output logic cond_src_a_o, // value of first source bit
  output logic cond_src_b_o, // value of second source bit
  output logic [2:0] dest_field_sel_o, // bits 6-8
  output logic [2:0] src_field_sel_o, // bits 11-13
  output logic [3:0] src_field_o, // selected source field
  output logic [ADDR_W-1:0] dest_field_mask_o, // target field bit mask
  output logic [ADDR_W-1:0] branch_target_o // resolved target
);

  // extract msb-numbered field first..last, right aligned
  function automatic logic [31:0] fld(input logic [31:0] w, input int first,
                                      input int last);
    logic [31:0] m;
    m = (32'h1 << (last - first + 1)) - 32'h1;
    return (w >> (31 - last)) & m;
  endfunction

  // msb-numbered register bit n
  function automatic logic rbit(input logic [31:0] r, input logic [4:0] n);
    return r[5'h1f - n];
  endfunction

  bfd_split_if split_bus ();

  logic [31:0] w;
  logic [4:0] idx_a;
  logic [4:0] idx_b;
  logic [2:0] dsel;
  logic [2:0] ssel;
  logic [31:0] src_reg;
  logic [3:0] next_src_field;
  logic [31:0] next_dest_mask;
  logic form_rsvd;
  logic next_invalid;
  logic [9:0] next_ext_op;
  logic [ADDR_W-1:0] disp;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] sum;
  logic [ADDR_W-1:0] next_target;
  logic [ADDR_W-1:0] narrow_keep;
  logic [23:0] ldisp;
  logic [13:0] cdisp;

  assign w = instr_i;
  assign split_bus.word = w;
  assign split_bus.swap = split_swap_i;

  bfd_field_split u_split (
    .sp (split_bus.worker)
  );

  assign idx_a = 5'(fld(w, `BFD_RA_FIRST, `BFD_RA_LAST));
  assign idx_b = 5'(fld(w, `BFD_RB_FIRST, `BFD_RB_LAST));
  assign dsel = 3'(fld(w, `BFD_DSEL_FIRST, `BFD_DSEL_LAST));
  assign ssel = 3'(fld(w, `BFD_SSEL_FIRST, `BFD_SSEL_LAST));
  assign src_reg = use_float_status_i ? float_status_ctrl_reg_i : condition_reg_i;

  // field j spans msb-numbered bits j*4 .. j*4+3
  always_comb begin
    next_src_field = src_reg[(5'h1f - {ssel, 2'h0}) -: `BFD_FIELD_BITS];
    next_dest_mask = 32'hf000_0000 >> {dsel, 2'h0};
  end

  // reserved bits of the form itself, plus the per-instruction table
  always_comb begin
    form_rsvd = 1'b0;
    if (form_i == bfd_pkg::BFD_FORM_XFL) begin
      form_rsvd = w[31-`BFD_XFL_RSVD_A] | w[31-`BFD_XFL_RSVD_B];
    end
    next_invalid = form_rsvd | (|(w & rsvd_mask_i))
                 | (|((w ^ fixed_value_i) & fixed_mask_i));
  end

  always_comb begin
    case (form_i)
      bfd_pkg::BFD_FORM_XOV: begin
        next_ext_op = 10'(fld(w, `BFD_EXT_OV_FIRST, `BFD_EXT_LAST));
      end
      bfd_pkg::BFD_FORM_A, bfd_pkg::BFD_FORM_M: begin
        next_ext_op = 10'(fld(w, `BFD_EXT_SHORT_FIRST, `BFD_EXT_LAST));
      end
      bfd_pkg::BFD_FORM_X, bfd_pkg::BFD_FORM_XFL: begin
        next_ext_op = 10'(fld(w, `BFD_EXT_LONG_FIRST, `BFD_EXT_LAST));
      end
      default: begin
        next_ext_op = 10'h000;
      end
    endcase
  end

  // branch target; the 32-bit variant wraps at 32 bits
  assign ldisp = 24'(fld(w, `BFD_LDISP_FIRST, `BFD_LDISP_LAST));
  assign cdisp = 14'(fld(w, `BFD_CDISP_FIRST, `BFD_CDISP_LAST));
  assign narrow_keep = wide_mode_i ? {ADDR_W{1'b1}}
                                   : {{(ADDR_W-`BFD_NARROW_WIDTH){1'b0}},
                                      {`BFD_NARROW_WIDTH{1'b1}}};

  always_comb begin
    if (form_i == bfd_pkg::BFD_FORM_B) begin
      disp = {{(ADDR_W-16){cdisp[13]}}, cdisp, 2'b00};
    end else begin
      disp = {{(ADDR_W-26){ldisp[23]}}, ldisp, 2'b00};
    end
    // fetch address low bits are ignored
    base = {instr_addr_i[ADDR_W-1:`BFD_ALIGN_BITS], 2'b00};
    sum = disp + base;
    if (w[31-`BFD_ABS_POS]) begin
      next_target = disp & narrow_keep;
    end else begin
      next_target = sum & narrow_keep;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      valid_o <= 1'b0;
    end else begin
      valid_o <= instr_valid_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      invalid_o <= 1'b0;
      primary_opcode_o <= 6'h00;
      record_bit_o <= 1'b0;
      absolute_addr_bit_o <= 1'b0;
      extended_opcode_o <= 10'h000;
      oe_bit_o <= 1'b0;
      rt_o <= 5'h00;
      ra_o <= 5'h00;
      rb_o <= 5'h00;
      src_c_o <= 5'h00;
      float_field_mask_o <= 8'h00;
      float_src_b_o <= 5'h00;
      split_field_o <= 10'h000;
    end else if (instr_valid_i) begin
      invalid_o <= next_invalid;
      primary_opcode_o <= 6'(fld(w, `BFD_OPCODE_FIRST, `BFD_OPCODE_LAST));
      record_bit_o <= w[31-`BFD_REC_POS];
      absolute_addr_bit_o <= w[31-`BFD_ABS_POS];
      extended_opcode_o <= next_ext_op;
      oe_bit_o <= (form_i == bfd_pkg::BFD_FORM_XOV) & w[31-`BFD_OE_POS];
      rt_o <= 5'(fld(w, `BFD_RT_FIRST, `BFD_RT_LAST));
      ra_o <= idx_a;
      rb_o <= idx_b;
      src_c_o <= 5'(fld(w, `BFD_SRC_C_FIRST, `BFD_SRC_C_LAST));
      float_field_mask_o <= 8'(fld(w, `BFD_FMASK_FIRST, `BFD_FMASK_LAST));
      float_src_b_o <= idx_b;
      split_field_o <= split_bus.value;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      branch_cond_bit_o <= 5'h00;
      branch_cond_o <= 1'b0;
      cond_src_a_o <= 1'b0;
      cond_src_b_o <= 1'b0;
      dest_field_sel_o <= 3'h0;
      src_field_sel_o <= 3'h0;
      src_field_o <= 4'h0;
      dest_field_mask_o <= {ADDR_W{1'b0}};
      branch_target_o <= {ADDR_W{1'b0}};
    end else if (instr_valid_i) begin
      branch_cond_bit_o <= idx_a;
      branch_cond_o <= rbit(condition_reg_i, idx_a);
      cond_src_a_o <= rbit(condition_reg_i, idx_a);
      cond_src_b_o <= rbit(condition_reg_i, idx_b);
      dest_field_sel_o <= dsel;
      src_field_sel_o <= ssel;
      src_field_o <= next_src_field;
      dest_field_mask_o <= {{(ADDR_W-32){1'b0}}, next_dest_mask};
      branch_target_o <= next_target;
    end
  end

endmodule // bfd_decoder

`default_nettype wire

/* src/bfd_params.svh */
// Purpose: constants for the branch field decoder
// Assumes: instruction bits numbered 0 (msb) to 31 (lsb)
// Notes: positions below use that msb-first numbering
`ifndef BFD_PARAMS_SVH
`define BFD_PARAMS_SVH

`define BFD_OPCODE_FIRST 0
`define BFD_OPCODE_LAST 5
`define BFD_LDISP_FIRST 6
`define BFD_LDISP_LAST 29
`define BFD_CDISP_FIRST 16
`define BFD_CDISP_LAST 29
`define BFD_ABS_POS 30
`define BFD_REC_POS 31
`define BFD_OE_POS 21
`define BFD_RT_FIRST 6
`define BFD_RT_LAST 10
`define BFD_RA_FIRST 11
`define BFD_RA_LAST 15
`define BFD_RB_FIRST 16
`define BFD_RB_LAST 20
`define BFD_SRC_C_FIRST 21
`define BFD_SRC_C_LAST 25
`define BFD_EXT_LONG_FIRST 21
`define BFD_EXT_OV_FIRST 22
`define BFD_EXT_SHORT_FIRST 26
`define BFD_EXT_LAST 30
`define BFD_DSEL_FIRST 6
`define BFD_DSEL_LAST 8
`define BFD_SSEL_FIRST 11
`define BFD_SSEL_LAST 13
`define BFD_FMASK_FIRST 7
`define BFD_FMASK_LAST 14
`define BFD_XFL_RSVD_A 6
`define BFD_XFL_RSVD_B 15
`define BFD_SPLIT_A_FIRST 11
`define BFD_SPLIT_A_LAST 15
`define BFD_SPLIT_B_FIRST 16
`define BFD_SPLIT_B_LAST 20
`define BFD_ALIGN_BITS 2
`define BFD_FIELD_BITS 4
`define BFD_NARROW_WIDTH 32

`endif

/* src/bfd_pkg.sv */
// Purpose: types shared by the branch field decoder files
// Assumes: nothing beyond the params header
// Notes: forms listed are those this decoder splits
package bfd_pkg;

  typedef enum logic [2:0] {
    BFD_FORM_I,
    BFD_FORM_B,
    BFD_FORM_X,
    BFD_FORM_XFL,
    BFD_FORM_XOV,
    BFD_FORM_A,
    BFD_FORM_M
  } bfd_form_t;

endpackage

/* src/bfd_split_if.sv */
// Purpose: carries a word and its reassembled split field between modules
// Assumes: single clock, combinational path
// Notes: none
`timescale 1ns/1ps
`default_nettype none

interface bfd_split_if;
  logic [31:0] word;
  logic swap;
  logic [9:0] value;

  modport requester (output word, output swap, input value);
  modport worker (input word, input swap, output value);
endinterface

`default_nettype wire

/* src/bfd_field_split.sv */
// Purpose: reassembles a two-part split field
// Assumes: parts sit at bits 11-15 and 16-20
// Notes: swap selects the per-instruction order of a capitalized field
`timescale 1ns/1ps
`default_nettype none
`include "bfd_params.svh"

module bfd_field_split (
  bfd_split_if.worker sp // word in, field out
);
  logic [4:0] part_a;
  logic [4:0] part_b;

  assign part_a = sp.word[31-`BFD_SPLIT_A_LAST +: 5];
  assign part_b = sp.word[31-`BFD_SPLIT_B_LAST +: 5];

  // lowercase name: sequences joined left to right
  // capitalized name: the instruction may reverse the order
  assign sp.value = sp.swap ? {part_b, part_a} : {part_a, part_b};
endmodule // bfd_field_split

`default_nettype wire

/* test/bfd_fetch_model.sv */
// Purpose: fetch-stage model handing instruction words to the decoder
// Assumes: one word per call, driven at the falling edge
// Notes: a released word bus shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none

module bfd_fetch_model (
  input wire logic clk_i, // core clock
  output logic valid_o, // word present
  output logic [31:0] word_o, // instruction word
  output logic [63:0] addr_o // fetch address
);
  initial begin
    valid_o = 1'h0;
    word_o = 32'h0;
    addr_o = 64'h0;
  end

  task automatic put(input logic [31:0] w, input logic [63:0] a);
    @(negedge clk_i);
    valid_o = 1'h1;
    word_o = w;
    addr_o = a;
    @(negedge clk_i);
    valid_o = 1'h0;
    word_o = ~w; // stale word must not look valid
  endtask
endmodule // bfd_fetch_model

`default_nettype wire

/* test/bfd_decoder_assertions.sv */
// Purpose: port-level checks of the decoder
// Assumes: fields answer one cycle after a taken word
// Notes: register bits are msb-numbered, so bit n is [31-n]
`timescale 1ns/1ps
`default_nettype none

module bfd_decoder_checker #(
  parameter int ADDR_W = 64
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] rsvd_mask_i,
  input wire logic [31:0] fixed_mask_i,
  input wire logic [31:0] fixed_value_i,
  input wire logic split_swap_i,
  input wire logic [31:0] condition_reg_i,
  input wire logic valid_o,
  input wire logic invalid_o,
  input wire logic [5:0] primary_opcode_o,
  input wire logic [9:0] split_field_o,
  input wire logic [4:0] branch_cond_bit_o,
  input wire logic cond_src_b_o,
  input wire logic [2:0] dest_field_sel_o,
  input wire logic [ADDR_W-1:0] branch_target_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_opcode_field: assert property (
    instr_valid_i |=> primary_opcode_o == $past(instr_i[31:26])) else $error("opcode wrong");
  a_target_aligned: assert property (
    valid_o |-> branch_target_o[1:0] == 2'h0) else $error("target not aligned");
  a_reserved_flag: assert property (
    instr_valid_i && |(instr_i & rsvd_mask_i) |=> invalid_o) else $error("reserved missed");
  a_fixed_flag: assert property (
    instr_valid_i && |((instr_i ^ fixed_value_i) & fixed_mask_i) |=> valid_o && invalid_o)
    else $error("fixed value missed");
  a_split_plain: assert property (
    instr_valid_i && !split_swap_i |=> split_field_o == $past(instr_i[20:11]))
    else $error("split order wrong");
  a_split_swapped: assert property (
    instr_valid_i && split_swap_i |=> split_field_o == {$past(instr_i[15:11]), $past(instr_i[20:16])})
    else $error("swapped split wrong");
  a_branch_index: assert property (
    instr_valid_i |=> branch_cond_bit_o == $past(instr_i[20:16])) else $error("branch bit wrong");
  a_second_source: assert property (
    instr_valid_i |=> cond_src_b_o == $past(condition_reg_i[~instr_i[15:11]]))
    else $error("second source wrong");
  a_dest_select: assert property (
    instr_valid_i |=> dest_field_sel_o == $past(instr_i[25:23])) else $error("dest select wrong");

  c_invalid: cover property (valid_o && invalid_o);
  c_swap: cover property (instr_valid_i && split_swap_i);
  c_absolute: cover property (instr_valid_i && instr_i[1]);
endmodule // bfd_decoder_checker

bind bfd_decoder bfd_decoder_checker #(.ADDR_W(ADDR_W)) chk_i (.clk_i, .nrst_i, .instr_valid_i,
  .instr_i, .rsvd_mask_i, .fixed_mask_i, .fixed_value_i, .split_swap_i, .condition_reg_i,
  .valid_o, .invalid_o, .primary_opcode_o, .split_field_o, .branch_cond_bit_o, .cond_src_b_o,
  .dest_field_sel_o, .branch_target_o);

`default_nettype wire

/* test/tb_branch_field_decoder.sv */
// Purpose: self-checking bench for the decoder
// Assumes: inputs change at the falling edge
// Notes: expected values are worked by hand from field positions
`timescale 1ns/1ps
`default_nettype none

module tb_branch_field_decoder;
  logic clk_i = 1'h0, nrst_i = 1'h0, wide_mode_i = 1'h1, split_swap_i = 1'h0;
  logic use_float_status_i = 1'h0;
  logic instr_valid_i;
  logic [31:0] instr_i, rsvd_mask_i = 32'h0, fixed_mask_i = 32'h0, fixed_value_i = 32'h0;
  logic [31:0] condition_reg_i = 32'h0, float_status_ctrl_reg_i = 32'h0;
  logic [63:0] instr_addr_i, dest_field_mask_o, branch_target_o;
  bfd_pkg::bfd_form_t form_i = bfd_pkg::BFD_FORM_A;
  logic valid_o, invalid_o, record_bit_o, absolute_addr_bit_o, oe_bit_o;
  logic branch_cond_o, cond_src_a_o, cond_src_b_o;
  logic [5:0] primary_opcode_o;
  logic [9:0] extended_opcode_o, split_field_o;
  logic [4:0] rt_o, ra_o, rb_o, src_c_o, float_src_b_o, branch_cond_bit_o;
  logic [7:0] float_field_mask_o;
  logic [2:0] dest_field_sel_o, src_field_sel_o;
  logic [3:0] src_field_o;
  int bad_count = 0, n_checks = 0;

  always #5 clk_i = ~clk_i;

  bfd_fetch_model fm (.clk_i, .valid_o(instr_valid_i), .word_o(instr_i), .addr_o(instr_addr_i));

  bfd_decoder #(.ADDR_W(64)) dut (.clk_i, .nrst_i, .instr_valid_i, .instr_i, .instr_addr_i,
    .form_i, .wide_mode_i, .rsvd_mask_i, .fixed_mask_i, .fixed_value_i, .split_swap_i,
    .use_float_status_i, .condition_reg_i, .float_status_ctrl_reg_i, .valid_o, .invalid_o,
    .primary_opcode_o, .record_bit_o, .absolute_addr_bit_o, .extended_opcode_o, .oe_bit_o,
    .rt_o, .ra_o, .rb_o, .src_c_o, .float_field_mask_o, .float_src_b_o, .split_field_o,
    .branch_cond_bit_o, .branch_cond_o, .cond_src_a_o, .cond_src_b_o, .dest_field_sel_o,
    .src_field_sel_o, .src_field_o, .dest_field_mask_o, .branch_target_o);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // returns at the falling edge where the answer stands
  task automatic dec(input logic [31:0] w, input logic [63:0] a);
    int n;
    fm.put(w, a);
    n = 0;
    while (valid_o !== 1'h1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 4) begin
      bad_count++;
      complete_run();
    end
  endtask

  task automatic inv(input bfd_pkg::bfd_form_t f, input logic [31:0] r, m, v, w);
    form_i = f;
    rsvd_mask_i = r;
    fixed_mask_i = m;
    fixed_value_i = v;
    dec(w, 64'h0);
  endtask

  task automatic s_fields();
    form_i = bfd_pkg::BFD_FORM_XOV;
    dec({6'h1f, 5'h03, 5'h0a, 5'h15, 1'h1, 9'h10a, 1'h1}, 64'h0);
    chk(primary_opcode_o, 6'h1f);
    chk({rt_o, ra_o, rb_o, oe_bit_o, extended_opcode_o, record_bit_o},
        {5'h03, 5'h0a, 5'h15, 1'h1, 10'h10a, 1'h1});
    form_i = bfd_pkg::BFD_FORM_A;
    dec({6'h3f, 5'h01, 5'h02, 5'h04, 5'h08, 5'h19, 1'h0}, 64'h0);
    chk({src_c_o, extended_opcode_o, oe_bit_o, record_bit_o}, {5'h08, 10'h019, 2'h0});
    form_i = bfd_pkg::BFD_FORM_M;
    dec({6'h1e, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 1'h1}, 64'h0);
    chk({src_c_o, extended_opcode_o, oe_bit_o, record_bit_o}, {5'h05, 10'h006, 2'h1});
    form_i = bfd_pkg::BFD_FORM_XFL;
    dec({6'h3f, 1'h0, 8'ha5, 1'h0, 5'h0c, 10'h2c7, 1'h1}, 64'h0);
    chk({float_field_mask_o, float_src_b_o, invalid_o}, {8'ha5, 5'h0c, 1'h0});
    chk({extended_opcode_o, record_bit_o}, {10'h2c7, 1'h1});
  endtask

  task automatic s_invalid();
    inv(bfd_pkg::BFD_FORM_XFL, 32'h0, 32'h0, 32'h0, 32'h02000000);
    chk(invalid_o, 1'h1);
    inv(bfd_pkg::BFD_FORM_XFL, 32'h0, 32'h0, 32'h0, 32'h00010000);
    chk(invalid_o, 1'h1);
    inv(bfd_pkg::BFD_FORM_A, 32'h000007c0, 32'h0, 32'h0, 32'h00000040);
    chk(invalid_o, 1'h1);
    inv(bfd_pkg::BFD_FORM_A, 32'h000007c0, 32'h0, 32'h0, 32'hfffff83f);
    chk(invalid_o, 1'h0);
    inv(bfd_pkg::BFD_FORM_A, 32'h0, 32'h0000003e, 32'h14, 32'h14);
    chk(invalid_o, 1'h0);
    inv(bfd_pkg::BFD_FORM_A, 32'h0, 32'h0000003e, 32'h14, 32'h16);
    chk(invalid_o, 1'h1);
    fixed_mask_i = 32'h0;
  endtask

  task automatic s_split();
    form_i = bfd_pkg::BFD_FORM_X;
    dec({11'h0, 5'h13, 5'h06, 11'h0}, 64'h0);
    chk(split_field_o, 10'h266);
    split_swap_i = 1'h1;
    dec({11'h0, 5'h13, 5'h06, 11'h0}, 64'h0);
    chk(split_field_o, 10'h0d3);
    split_swap_i = 1'h0;
  endtask

  task automatic s_branch();
    form_i = bfd_pkg::BFD_FORM_I;
    dec({6'h12, 24'hfffffe, 2'h0}, 64'h10003);
    chk(branch_target_o, 64'hfff8);
    chk({absolute_addr_bit_o, extended_opcode_o}, 11'h000);
    dec({6'h12, 24'h000040, 2'h3}, 64'h10003);
    chk(branch_target_o, 64'h100);
    chk(absolute_addr_bit_o, 1'h1);
    form_i = bfd_pkg::BFD_FORM_B;
    dec({6'h10, 10'h182, 14'h3ffc, 2'h0}, 64'h10000);
    chk(branch_target_o, 64'hfff0);
    dec({6'h10, 10'h182, 14'h2000, 2'h2}, 64'h10000);
    chk(branch_target_o, 64'hffffffffffff8000);
    wide_mode_i = 1'h0;
    dec({6'h10, 10'h182, 14'h2000, 2'h2}, 64'h10000);
    chk(branch_target_o, 64'hffff8000);
    wide_mode_i = 1'h1;
  endtask

  task automatic s_cr();
    form_i = bfd_pkg::BFD_FORM_X;
    condition_reg_i = 32'h80000001;
    float_status_ctrl_reg_i = 32'h0000000a;
    dec({6'h13, 3'h5, 2'h0, 5'h00, 5'h1f, 11'h0}, 64'h0);
    chk({cond_src_a_o, cond_src_b_o, branch_cond_o}, 3'h7);
    chk(dest_field_mask_o, 64'hf00);
    chk(dest_field_sel_o, 3'h5);
    chk({src_field_sel_o, src_field_o}, {3'h0, 4'h8});
    use_float_status_i = 1'h1;
    dec({6'h13, 3'h0, 2'h0, 5'h1c, 5'h1e, 11'h0}, 64'h0);
    chk({cond_src_a_o, cond_src_b_o, branch_cond_bit_o, branch_cond_o}, {7'h1c, 1'h0});
    chk(dest_field_mask_o, 64'hf0000000);
    chk({src_field_sel_o, src_field_o}, {3'h7, 4'ha});
  endtask

  initial begin
    repeat (16) @(negedge clk_i);
    nrst_i = 1'h1;
    s_fields();
    s_invalid();
    s_split();
    s_branch();
    s_cr();
    complete_run();
  end
endmodule // tb_branch_field_decoder

`default_nettype wire
